// ### hub_cfg_defines.vh
// Offsets, reset values and timing figures of the hub configuration bank.
// Assumes inclusion by bare name; definitions only.
`ifndef HUB_CFG_DEFINES_VH
`define HUB_CFG_DEFINES_VH

// Register indices; byte address on APB is four times the index
`define IDX_BP_MAX_POWER       10'h00d
`define IDX_SP_CTRL_CURRENT    10'h00e
`define IDX_BP_CTRL_CURRENT    10'h00f
`define IDX_POWER_ON_DELAY     10'h010
`define IDX_LANG_HIGH          10'h011
`define IDX_LANG_LOW           10'h012
`define IDX_MAKER_LEN          10'h013
`define IDX_PRODUCT_LEN        10'h014
`define IDX_SERIAL_LEN         10'h015
`define IDX_MAKER_TEXT_FIRST   10'h016
`define IDX_MAKER_TEXT_LAST    10'h053
`define IDX_HUB_STATUS         10'h060

// Status register field positions
`define STAT_SELF_POWERED      0
`define STAT_PORT_POWER_GOOD   1
`define STAT_TIMER_BUSY        2

// Reset values
`define RST_CTRL_CURRENT       8'h32
`define RST_CFG_BYTE           8'h00

// Limits and units
`define TEXT_MAX_CHARS         5'h1f
`define TEXT_BYTES             62
`define CURRENT_UNIT_SHIFT     1

// Timing: one power-on unit is 2 ms, pclk period is 40 ns
`define POWER_UNIT_NS          2000000
`define PCLK_PERIOD_NS         40

`endif

// ### cfg_byte_reg.v
// One byte-wide software-writable configuration register.
// Assumes the write strobe is already decoded on the pclk domain.
`timescale 1ns/10ps
`default_nettype none

module cfg_byte_reg #(
  parameter [7:0] RESET_VALUE = 8'h00
) (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Write side
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  // Stored value
  output reg  [7:0] value_ff
);

  // Value loads only on the decoded write edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_ff <= RESET_VALUE;
    end else if (wr_en) begin
      value_ff <= wr_data;
    end
  end

endmodule

`default_nettype wire

// ### unit_tick_gen.v
// Divider giving a one-cycle enable pulse every TICK_CYCLES clocks.
// Assumes run is a same-clock level; dropping it restarts the count.
`timescale 1ns/10ps
`default_nettype none

module unit_tick_gen #(
  parameter TICK_CYCLES = 50000
) (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Control
  input  wire run,
  // Enable pulse
  output reg  tick_ff
);

  reg  [31:0] count_ff;
  wire        at_end;

  assign at_end = (count_ff == TICK_CYCLES - 1);

  // Held in restart while idle so the first tick is a full unit away
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 32'h0000_0000;
      tick_ff  <= 1'b0;
    end else if (!run) begin
      count_ff <= 32'h0000_0000;
      tick_ff  <= 1'b0;
    end else begin
      tick_ff  <= at_end;
      count_ff <= at_end ? 32'h0000_0000 : count_ff + 32'h0000_0001;
    end
  end

endmodule

`default_nettype wire

// ### hub_power_string_config_regs.v
// Power and string configuration bank of a USB hub, with APB access.
// Assumes an APB3 master on pclk; self_powered_pin is asynchronous;
// descriptor-side inputs come from logic on pclk.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "hub_cfg_defines.vh"

// Operation
// - Bus-powered max power counts 2 mA steps of total upstream draw.
// - Embedded compound function always advertises zero current itself.
// - Self-powered controller current counts 2 mA, no attached peripheral.
// - Self-powered controller current resets to 50, meaning 100 mA.
// - Bus-powered controller current counts 2 mA, hub and board only.
// - Bus-powered controller current resets to 50, meaning 100 mA.
// - Port power-on delay counts 2 ms units from power-on start.
// - Language ID is high byte at 0x11 and low byte at 0x12.
// - Maker text length is in characters, at most 31.
// - Product text length is in characters, at most 31.
// - Serial text length is in characters, at most 31.
// - Maker text bytes occupy offsets 0x16 through 0x53.
// - Each character is low byte first, characters packed contiguously.
module hub_power_string_config_regs #(
  parameter UNIT_CYCLES = `POWER_UNIT_NS / `PCLK_PERIOD_NS
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg         pready_ff,
  output reg  [31:0] prdata_ff,
  output reg         pslverr_ff,
  // Power mode strap, asynchronous
  input  wire        self_powered_pin,
  // Descriptor builder side
  input  wire        port_power_start,
  input  wire [4:0]  maker_char_index,
  // Figures reported upstream
  output reg  [8:0]  max_power_ma_ff,
  output reg  [7:0]  max_power_code_ff,
  output reg  [7:0]  embedded_current_ff,
  output reg  [7:0]  ctrl_current_code_ff,
  output reg  [8:0]  ctrl_current_ma_ff,
  output reg  [7:0]  power_on_delay_code_ff,
  output reg         port_power_good_ff,
  output reg         self_powered_ff,
  // Language and strings
  output reg  [15:0] language_id_ff,
  output reg  [4:0]  maker_len_ff,
  output reg  [4:0]  product_len_ff,
  output reg  [4:0]  serial_len_ff,
  output reg  [15:0] maker_char_ff
);

  // Timer states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_GOOD = 3'b100;

  // APB decode
  wire [9:0] reg_idx;
  wire       aligned;
  wire       setup_phase;
  wire       wr_commit;
  wire [9:0] text_off;
  wire       in_text;

  assign reg_idx     = paddr[11:2];
  assign aligned     = (paddr[1:0] == 2'b00);
  assign setup_phase = psel & ~penable;
  assign wr_commit   = psel & penable & pready_ff & pwrite & aligned;
  assign text_off    = reg_idx - `IDX_MAKER_TEXT_FIRST;
  assign in_text     = (reg_idx >= `IDX_MAKER_TEXT_FIRST) &&
                       (reg_idx <= `IDX_MAKER_TEXT_LAST);

  // Per-register write strobes, taken only at the access edge
  wire we_bp_max   = wr_commit & (reg_idx == `IDX_BP_MAX_POWER);
  wire we_sp_cur   = wr_commit & (reg_idx == `IDX_SP_CTRL_CURRENT);
  wire we_bp_cur   = wr_commit & (reg_idx == `IDX_BP_CTRL_CURRENT);
  wire we_pon      = wr_commit & (reg_idx == `IDX_POWER_ON_DELAY);
  wire we_lang_h   = wr_commit & (reg_idx == `IDX_LANG_HIGH);
  wire we_lang_l   = wr_commit & (reg_idx == `IDX_LANG_LOW);
  wire we_mlen     = wr_commit & (reg_idx == `IDX_MAKER_LEN);
  wire we_plen     = wr_commit & (reg_idx == `IDX_PRODUCT_LEN);
  wire we_slen     = wr_commit & (reg_idx == `IDX_SERIAL_LEN);
  wire we_text     = wr_commit & in_text;

  // Stored configuration bytes
  wire [7:0] bp_max_power;
  wire [7:0] sp_ctrl_current;
  wire [7:0] bp_ctrl_current;
  wire [7:0] power_on_delay;
  wire [7:0] lang_high;
  wire [7:0] lang_low;
  wire [7:0] maker_len;
  wire [7:0] product_len;
  wire [7:0] serial_len;

  cfg_byte_reg #(.RESET_VALUE(`RST_CFG_BYTE)) u_bp_max_power (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (we_bp_max),
    .wr_data  (pwdata[7:0]),
    .value_ff (bp_max_power)
  );

  // Controller current bytes come out of reset at 100 mA
  cfg_byte_reg #(.RESET_VALUE(`RST_CTRL_CURRENT)) u_sp_ctrl_current (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (we_sp_cur),
    .wr_data  (pwdata[7:0]),
    .value_ff (sp_ctrl_current)
  );

  cfg_byte_reg #(.RESET_VALUE(`RST_CTRL_CURRENT)) u_bp_ctrl_current (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (we_bp_cur),
    .wr_data  (pwdata[7:0]),
    .value_ff (bp_ctrl_current)
  );

  cfg_byte_reg #(.RESET_VALUE(`RST_CFG_BYTE)) u_power_on_delay (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (we_pon),
    .wr_data  (pwdata[7:0]),
    .value_ff (power_on_delay)
  );

  cfg_byte_reg #(.RESET_VALUE(`RST_CFG_BYTE)) u_lang_high (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (we_lang_h),
    .wr_data  (pwdata[7:0]),
    .value_ff (lang_high)
  );

  cfg_byte_reg #(.RESET_VALUE(`RST_CFG_BYTE)) u_lang_low (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (we_lang_l),
    .wr_data  (pwdata[7:0]),
    .value_ff (lang_low)
  );

  cfg_byte_reg #(.RESET_VALUE(`RST_CFG_BYTE)) u_maker_len (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (we_mlen),
    .wr_data  (pwdata[7:0]),
    .value_ff (maker_len)
  );

  cfg_byte_reg #(.RESET_VALUE(`RST_CFG_BYTE)) u_product_len (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (we_plen),
    .wr_data  (pwdata[7:0]),
    .value_ff (product_len)
  );

  cfg_byte_reg #(.RESET_VALUE(`RST_CFG_BYTE)) u_serial_len (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (we_slen),
    .wr_data  (pwdata[7:0]),
    .value_ff (serial_len)
  );

  // Maker text store, one byte per index, as written
  reg [7:0] text_mem [0:`TEXT_BYTES-1];
  integer   i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `TEXT_BYTES; i = i + 1) begin
        text_mem[i] <= `RST_CFG_BYTE;
      end
    end else if (we_text) begin
      text_mem[text_off[5:0]] <= pwdata[7:0];
    end
  end

  // Power mode strap, two flip-flops before use
  reg sp_meta_ff;
  reg sp_sync_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_meta_ff <= 1'b0;
      sp_sync_ff <= 1'b0;
    end else begin
      sp_meta_ff <= self_powered_pin;
      sp_sync_ff <= sp_meta_ff;
    end
  end

  // Port power-on timer in 2 ms units
  reg  [2:0] state_ff;
  reg  [2:0] nxt_state;
  reg  [7:0] units_left_ff;
  reg  [7:0] nxt_units_left;
  wire       unit_tick;

  unit_tick_gen #(.TICK_CYCLES(UNIT_CYCLES)) u_unit_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (state_ff == ST_WAIT && !port_power_start),
    .tick_ff (unit_tick)
  );

  // A new start always restarts; a zero delay is good at once
  always @* begin
    nxt_state      = state_ff;
    nxt_units_left = units_left_ff;
    case (state_ff)
      ST_IDLE, ST_GOOD: begin
        if (port_power_start) begin
          nxt_units_left = power_on_delay;
          nxt_state = (power_on_delay == 8'h00) ? ST_GOOD : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (port_power_start) begin
          nxt_units_left = power_on_delay;
          nxt_state = (power_on_delay == 8'h00) ? ST_GOOD : ST_WAIT;
        end else if (unit_tick) begin
          nxt_units_left = units_left_ff - 8'h01;
          if (units_left_ff == 8'h01) begin
            nxt_state = ST_GOOD;
          end
        end
      end
      default: begin
        nxt_state      = ST_IDLE;
        nxt_units_left = 8'h00;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff      <= ST_IDLE;
      units_left_ff <= 8'h00;
    end else begin
      state_ff      <= nxt_state;
      units_left_ff <= nxt_units_left;
    end
  end

  // Length clamp: only 31 characters fit behind each length byte
  function [4:0] clamp_len;
    input [7:0] raw;
    begin
      if (raw > {3'b000, `TEXT_MAX_CHARS}) begin
        clamp_len = `TEXT_MAX_CHARS;
      end else begin
        clamp_len = raw[4:0];
      end
    end
  endfunction

  // Character fetch: low byte at even index, high byte just above it
  wire [5:0] char_lo_idx;
  wire [5:0] char_hi_idx;
  wire       char_valid;

  assign char_lo_idx = {maker_char_index, 1'b0};
  assign char_hi_idx = {maker_char_index, 1'b1};
  assign char_valid  = (maker_char_index < 5'h1f);

  // Upstream-facing figures, all registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_power_ma_ff        <= 9'h000;
      max_power_code_ff      <= 8'h00;
      embedded_current_ff    <= 8'h00;
      ctrl_current_code_ff   <= 8'h00;
      ctrl_current_ma_ff     <= 9'h000;
      power_on_delay_code_ff <= 8'h00;
      port_power_good_ff     <= 1'b0;
      self_powered_ff        <= 1'b0;
      language_id_ff         <= 16'h0000;
      maker_len_ff           <= 5'h00;
      product_len_ff         <= 5'h00;
      serial_len_ff          <= 5'h00;
      maker_char_ff          <= 16'h0000;
    end else begin
      max_power_code_ff   <= bp_max_power;
      max_power_ma_ff     <= {bp_max_power, 1'b0};
      embedded_current_ff <= 8'h00;
      self_powered_ff     <= sp_sync_ff;
      if (sp_sync_ff) begin
        ctrl_current_code_ff <= sp_ctrl_current;
        ctrl_current_ma_ff   <= {sp_ctrl_current, 1'b0};
      end else begin
        ctrl_current_code_ff <= bp_ctrl_current;
        ctrl_current_ma_ff   <= {bp_ctrl_current, 1'b0};
      end
      power_on_delay_code_ff <= power_on_delay;
      port_power_good_ff     <= (nxt_state == ST_GOOD);
      language_id_ff  <= {lang_high, lang_low};
      maker_len_ff    <= clamp_len(maker_len);
      product_len_ff  <= clamp_len(product_len);
      serial_len_ff   <= clamp_len(serial_len);
      if (char_valid) begin
        maker_char_ff <= {text_mem[char_hi_idx],
                          text_mem[char_lo_idx]};
      end else begin
        maker_char_ff <= 16'h0000;
      end
    end
  end

  // Read mux; unmapped or misaligned addresses answer with an error
  reg [7:0] rd_byte;
  reg       rd_hit;

  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (reg_idx)
      `IDX_BP_MAX_POWER:    rd_byte = bp_max_power;
      `IDX_SP_CTRL_CURRENT: rd_byte = sp_ctrl_current;
      `IDX_BP_CTRL_CURRENT: rd_byte = bp_ctrl_current;
      `IDX_POWER_ON_DELAY:  rd_byte = power_on_delay;
      `IDX_LANG_HIGH:       rd_byte = lang_high;
      `IDX_LANG_LOW:        rd_byte = lang_low;
      `IDX_MAKER_LEN:       rd_byte = maker_len;
      `IDX_PRODUCT_LEN:     rd_byte = product_len;
      `IDX_SERIAL_LEN:      rd_byte = serial_len;
      `IDX_HUB_STATUS: begin
        rd_byte[`STAT_SELF_POWERED]    = sp_sync_ff;
        rd_byte[`STAT_PORT_POWER_GOOD] = (state_ff == ST_GOOD);
        rd_byte[`STAT_TIMER_BUSY]      = (state_ff == ST_WAIT);
      end
      default: begin
        if (in_text) begin
          rd_byte = text_mem[text_off[5:0]];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
    if (!aligned) begin
      rd_hit  = 1'b0;
      rd_byte = 8'h00;
    end
  end

  // Answer prepared in setup, presented for exactly one access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff   <= 1'b0;
      prdata_ff   <= 32'h0000_0000;
      pslverr_ff  <= 1'b0;
    end else begin
      pready_ff <= setup_phase;
      if (setup_phase) begin
        pslverr_ff  <= ~rd_hit | (pwrite & (reg_idx == `IDX_HUB_STATUS));
        prdata_ff   <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end else begin
        pslverr_ff <= 1'b0;
        prdata_ff  <= 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

// ### hub_cfg_checker.sv
// Port-level assertions for the hub power and string configuration bank.
// Assumes APB on pclk and presetn as the only reset.
`timescale 1ns/10ps
`default_nettype none

module hub_cfg_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready_ff,
  input wire logic [31:0] prdata_ff,
  input wire logic        pslverr_ff,
  // Reported figures
  input wire logic [8:0]  max_power_ma_ff,
  input wire logic [7:0]  max_power_code_ff,
  input wire logic [7:0]  embedded_current_ff,
  input wire logic [7:0]  ctrl_current_code_ff,
  input wire logic [8:0]  ctrl_current_ma_ff,
  input wire logic [7:0]  power_on_delay_code_ff,
  input wire logic [15:0] language_id_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Committed write, as seen on the bus
  wire wr_done = psel && penable && pready_ff && pwrite && !pslverr_ff;

  a_max_power_ma: assert property (
    max_power_ma_ff == {max_power_code_ff, 1'b0})
    else $error("max power mA is not twice the code");
  a_embedded_zero: assert property (
    embedded_current_ff == 8'h00)
    else $error("embedded function current not zero");
  a_ctrl_current_ma: assert property (
    ctrl_current_ma_ff == {ctrl_current_code_ff, 1'b0})
    else $error("controller mA is not twice the code");
  a_apb_answer: assert property (
    psel && !penable |=> pready_ff)
    else $error("no answer in the access cycle");
  a_pready_pulse: assert property (
    pready_ff |=> !pready_ff)
    else $error("pready stood more than one cycle");
  a_lang_high: assert property (
    wr_done && paddr == 12'h044 |->
      ##2 language_id_ff[15:8] == $past(pwdata[7:0], 2))
    else $error("language high byte not taken from 0x11");
  a_lang_low: assert property (
    wr_done && paddr == 12'h048 |->
      ##2 language_id_ff[7:0] == $past(pwdata[7:0], 2))
    else $error("language low byte not taken from 0x12");
  a_delay_code: assert property (
    wr_done && paddr == 12'h040 |->
      ##2 power_on_delay_code_ff == $past(pwdata[7:0], 2))
    else $error("power-on delay code not updated");
  a_past_text_end: assert property (
    psel && !penable && paddr[11:2] > 10'h053 && paddr[11:2] < 10'h060
      |=> pslverr_ff && prdata_ff == 32'h0000_0000)
    else $error("place after the maker text not refused");
endmodule

bind hub_power_string_config_regs hub_cfg_checker u_hub_cfg_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready_ff,
  .prdata_ff, .pslverr_ff, .max_power_ma_ff, .max_power_code_ff,
  .embedded_current_ff, .ctrl_current_code_ff, .ctrl_current_ma_ff,
  .power_on_delay_code_ff, .language_id_ff
);
`default_nettype wire

// ### upstream_host_model.sv
// Upstream host side: starts port power-on and walks maker characters.
// Assumes the bench calls its tasks; signals move right after pclk rises.
`timescale 1ns/10ps
`default_nettype none

module upstream_host_model (
  // Clock
  input  wire logic       pclk,
  // Requests to the hub
  output var  logic       port_power_start,
  output var  logic [4:0] maker_char_index
);
  initial begin
    port_power_start = 1'b0;
    maker_char_index = 5'h00;
  end

  // One-cycle power-on request; the hub then owns the wait
  task automatic power_on();
    @(posedge pclk);
    port_power_start <= 1'b1;
    @(posedge pclk);
    port_power_start <= 1'b0;
  endtask

  // Pick which 16-bit character the descriptor builder asks for
  task automatic pick_char(input logic [4:0] idx);
    @(posedge pclk);
    maker_char_index <= idx;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench of the hub configuration bank over APB.
// Assumes the checker is bound and the host model compiled beforehand.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int UNIT = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        self_powered_pin = 1'b0;
  wire         pready_ff, pslverr_ff, port_power_start;
  wire         port_power_good_ff, self_powered_ff;
  wire  [31:0] prdata_ff;
  wire  [15:0] language_id_ff, maker_char_ff;
  wire  [8:0]  max_power_ma_ff, ctrl_current_ma_ff;
  wire  [7:0]  max_power_code_ff, embedded_current_ff;
  wire  [7:0]  ctrl_current_code_ff, power_on_delay_code_ff;
  wire  [4:0]  maker_len_ff, product_len_ff, serial_len_ff;
  wire  [4:0]  maker_char_index;
  int          num_errors = 0;
  int          checks_done = 0;
  int          n;
  logic [31:0] rdv;
  logic        errv;

  // 25 MHz clock
  always #20 pclk = ~pclk;

  hub_power_string_config_regs #(
    .UNIT_CYCLES(UNIT)
  ) u_hub_power_string_config_regs (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready_ff,
    .prdata_ff, .pslverr_ff, .self_powered_pin, .port_power_start,
    .maker_char_index, .max_power_ma_ff, .max_power_code_ff,
    .embedded_current_ff, .ctrl_current_code_ff, .ctrl_current_ma_ff,
    .power_on_delay_code_ff, .port_power_good_ff, .self_powered_ff,
    .language_id_ff, .maker_len_ff, .product_len_ff, .serial_len_ff,
    .maker_char_ff
  );

  upstream_host_model u_upstream_host_model (
    .pclk, .port_power_start, .maker_char_index
  );

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready however long it takes
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_ff !== 1'b1);
    rd = prdata_ff;
    err = pslverr_ff;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, d, rd, err);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] exp,
                    input logic err_exp);
    logic [31:0] rdat;
    logic        err;
    apb(1'b0, idx, 8'h00, rdat, err);
    chk($sformatf("read %h", idx), rdat, {24'h00_0000, exp});
    chk($sformatf("error %h", idx), {31'h0, err}, {31'h0, err_exp});
  endtask

  // Outputs lag a stored byte by one more edge
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic results();
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, well beyond the hundred-odd cycles the run needs
  initial begin
    #400000;
    num_errors++;
    results();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("ctrl code", ctrl_current_code_ff, 8'h32);
    chk("ctrl mA", ctrl_current_ma_ff, 9'h064);
    for (int i = 13; i < 23; i++)
      rd(i[9:0], (i == 14 || i == 15) ? 8'h32 : 8'h00, 1'b0);
    // Controller currents stay at or under 100 mA
    wr(10'h00d, 8'h7f);
    wr(10'h00e, 8'h28);
    wr(10'h00f, 8'h19);
    settle();
    chk("max power code", max_power_code_ff, 8'h7f);
    chk("max power mA", max_power_ma_ff, 9'h0fe);
    chk("embedded", embedded_current_ff, 8'h00);
    chk("bus ctrl code", ctrl_current_code_ff, 8'h19);
    chk("bus ctrl mA", ctrl_current_ma_ff, 9'h032);
    // Strap moves on a clock edge like every other bench input
    @(posedge pclk);
    self_powered_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    #1;
    chk("self mode", self_powered_ff, 1'b1);
    chk("self ctrl code", ctrl_current_code_ff, 8'h28);
    chk("self ctrl mA", ctrl_current_ma_ff, 9'h050);
    wr(10'h011, 8'h04);
    wr(10'h012, 8'h09);
    wr(10'h013, 8'h1f);
    wr(10'h014, 8'h28);
    wr(10'h015, 8'h05);
    settle();
    chk("language", language_id_ff, 16'h0409);
    chk("maker len", maker_len_ff, 5'h1f);
    chk("product len", product_len_ff, 5'h1f);
    chk("serial len", serial_len_ff, 5'h05);
    rd(10'h014, 8'h28, 1'b0);
    // Characters loaded low byte first
    wr(10'h016, 8'h41);
    wr(10'h017, 8'h00);
    wr(10'h052, 8'h34);
    wr(10'h053, 8'h12);
    u_upstream_host_model.pick_char(5'd0);
    settle();
    chk("char 0", maker_char_ff, 16'h0041);
    u_upstream_host_model.pick_char(5'd30);
    settle();
    chk("char 30", maker_char_ff, 16'h1234);
    rd(10'h054, 8'h00, 1'b1);
    wr(10'h010, 8'h02);
    settle();
    chk("delay code", power_on_delay_code_ff, 8'h02);
    u_upstream_host_model.power_on();
    repeat (3) @(posedge pclk);
    #1;
    chk("good early", port_power_good_ff, 1'b0);
    n = 3;
    while (port_power_good_ff !== 1'b1 && n < 30) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("good lag", n >= 2 * UNIT && n <= 2 * UNIT + 4, 1'b1);
    // Status: self-powered and power good, timer no longer busy
    rd(10'h060, 8'h03, 1'b0);
    apb(1'b1, 10'h060, 8'hff, rdv, errv);
    chk("status write", {31'h0, errv}, 32'h0000_0001);
    results();
  end
endmodule
`default_nettype wire
